// File: core_interrupt_control.sv
// interrupt control register with flags, enables and request to the core
// assumes a synchronous apb master, inputs synchronous to mclk
//
// Notes on behaviour
// R1: bit 7 globally enables all interrupts
// R2: peripheral group enable gates peripheral sources
// R3: timer0 overflow enable gates timer0 request
// R4: external pin enable gates external request
// R5: port b change enable gates change request
// R6: software must also set per-pin enables
// R7: timer0 flag set on rollover, sticky
// R8: timer0 count untouched by reset
// R9: external pin edge sets sticky flag
// R10: any port b pin change sets flag; here only a change on a pin enabled in per_pin_change_enable_reg sets it
// R11: flags set regardless of enable bits
// R12: software clears flags before enabling sources
// R13: register read/write, upper bits reset zero
// R14: per-pin change detect and pull-up enables
// R15: request when global and enabled flag set
//
// Our own choices: register access over APB and the placing of the registers.
`include "core_interrupt_control_map.svh"
`timescale 1ns/1ps
`default_nettype none

module core_interrupt_control
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire core_interrupt_control_pkg::apb_req_t apb_req,
  output core_interrupt_control_pkg::apb_rsp_t apb_rsp,
  input wire logic timer0_rollover,
  input wire logic ext_pin,
  input wire logic [7:0] port_b_a,
  input wire logic peripheral_irq,
  output logic [7:0] pullup_enable,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] reset_sync;
  logic reset_q_n;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      reset_sync <= 2'h0;
    else
      reset_sync <= {reset_sync[0], 1'b1};
  end

  assign reset_q_n = reset_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] pack_ctl(
    input core_interrupt_control_pkg::interrupt_control_t c);
    pack_ctl = c;
  endfunction : pack_ctl

  function automatic logic is_at(input logic [11:0] a, input logic [11:0] o);
    is_at = (a == o);
  endfunction : is_at

  // an 8-bit register in the low byte of the bus word
  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction : byte_word

  // sticky flag: a set in the clearing cycle wins
  function automatic logic next_flag(
    input logic flag,
    input logic set,
    input logic clear);
    if (set)
    begin
      next_flag = 1'b1;
    end
    else if (clear)
    begin
      next_flag = 1'b0;
    end
    else
    begin
      next_flag = flag;
    end
  endfunction : next_flag

  // enabled pins whose level differs from the last sample
  function automatic logic [7:0] pin_changes(
    input logic [7:0] now,
    input logic [7:0] last,
    input logic [7:0] enable);
    pin_changes = (now ^ last) & enable;
  endfunction : pin_changes

  function automatic logic rising(input logic now, input logic last);
    rising = now && !last;
  endfunction : rising

  // request to the core from enables and flags
  function automatic logic request(
    input core_interrupt_control_pkg::interrupt_control_t c,
    input logic periph);
    logic core_src;
    logic periph_src;
    core_src = (c.timer0_overflow_irq_enable && c.timer0_overflow_flag) || // R3
      (c.ext_pin_irq_enable && c.ext_pin_irq_flag) || // R4
      (c.port_b_change_irq_enable && c.port_b_change_flag); // R5
    periph_src = c.peripheral_group_enable && periph; // R2
    request = c.global_irq_enable && (core_src || periph_src); // R1 R15
  endfunction : request

  // one-hot write strobes: control, change enables, pull-ups
  function automatic logic [2:0] write_sel(
    input logic w,
    input logic [11:0] a);
    if (!w)
    begin
      write_sel = 3'h0;
    end
    else if (is_at(a, `ICTL_OFS_CONTROL))
    begin
      write_sel = 3'h1;
    end
    else if (is_at(a, `ICTL_OFS_PIN_ENABLE))
    begin
      write_sel = 3'h2;
    end
    else if (is_at(a, `ICTL_OFS_PULLUP))
    begin
      write_sel = 3'h4;
    end
    else
    begin
      write_sel = 3'h0;
    end
  endfunction : write_sel

  // read word: error flag above the 32 data bits
  function automatic logic [32:0] read_word(
    input logic [11:0] a,
    input core_interrupt_control_pkg::state_t s,
    input logic [7:0] pins);
    if (is_at(a, `ICTL_OFS_CONTROL))
    begin
      read_word = {1'b0, byte_word(pack_ctl(s.interrupt_control))}; // R13
    end
    else if (is_at(a, `ICTL_OFS_PIN_ENABLE))
    begin
      read_word = {1'b0, byte_word(s.per_pin_change_enable_reg)};
    end
    else if (is_at(a, `ICTL_OFS_PORT_B))
    begin
      read_word = {1'b0, byte_word(pins)};
    end
    else if (is_at(a, `ICTL_OFS_PULLUP))
    begin
      read_word = {1'b0, byte_word(s.pullup_enable)};
    end
    else if (is_at(a, `ICTL_OFS_STATUS))
    begin
      read_word = {1'b0, 31'h0000_0000, s.irq};
    end
    else
    begin
      read_word = {1'b1, 32'h0000_0000};
    end
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // state

  core_interrupt_control_pkg::state_t state;
  core_interrupt_control_pkg::state_t next_state;
  core_interrupt_control_pkg::interrupt_control_t ctl;
  core_interrupt_control_pkg::interrupt_control_t wctl;
  logic access;
  logic wr;
  logic [2:0] wsel;
  logic [32:0] rdword;
  logic [7:0] change;
  logic ext_rise;
  logic clear_t0;
  logic clear_ext;
  logic clear_pb;

  always_comb
  begin
    next_state = state;
    ctl = state.interrupt_control;
    access = apb_req.psel && apb_req.penable;
    wr = access && apb_req.pwrite;
    wsel = write_sel(wr, apb_req.paddr);
    wctl = apb_req.pwdata[7:0];
    rdword = read_word(apb_req.paddr, state, port_b_a); // R13
    clear_t0 = 1'b0;
    clear_ext = 1'b0;
    clear_pb = 1'b0;
    // the apb slave answers in the first access cycle
    next_state.rsp.pready = 1'b0;
    next_state.rsp.pslverr = 1'b0;
    next_state.rsp.prdata = 32'h0000_0000;
    if (apb_req.psel && !apb_req.penable)
    begin
      next_state.rsp.pready = 1'b1;
      next_state.rsp.pslverr = rdword[32];
      next_state.rsp.prdata = rdword[31:0];
    end
    // register writes; a write to a flag stores the written value unless its event sets the flag in that cycle
    if (wsel[0])
    begin
      next_state.interrupt_control = wctl; // R13
      clear_t0 = !wctl.timer0_overflow_flag;
      clear_ext = !wctl.ext_pin_irq_flag;
      clear_pb = !wctl.port_b_change_flag;
    end
    else if (wsel[1])
    begin
      next_state.per_pin_change_enable_reg = apb_req.pwdata[7:0]; // R14
    end
    else if (wsel[2])
    begin
      next_state.pullup_enable = apb_req.pwdata[7:0]; // R14
    end
    // event detection
    change = pin_changes(port_b_a, state.port_b_last,
      state.per_pin_change_enable_reg); // R6 R14
    ext_rise = rising(ext_pin, state.ext_pin_last);
    next_state.port_b_last = port_b_a;
    next_state.ext_pin_last = ext_pin;
    next_state.timer0_pending = 1'b0;
    // timer0 count lives outside; reset only touches the flag R8
    next_state.interrupt_control.timer0_overflow_flag = next_flag(
      next_state.interrupt_control.timer0_overflow_flag,
      timer0_rollover, clear_t0); // R7 R11
    next_state.interrupt_control.ext_pin_irq_flag = next_flag(
      next_state.interrupt_control.ext_pin_irq_flag,
      ext_rise, clear_ext); // R9 R11
    next_state.interrupt_control.port_b_change_flag = next_flag(
      next_state.interrupt_control.port_b_change_flag,
      |change, clear_pb); // R10 R11
    // request to the core, from the registered enables and flags
    next_state.irq = request(ctl, peripheral_irq); // R15
  end

  always_ff @(posedge mclk or negedge reset_q_n)
  begin
    if (!reset_q_n)
    begin
      state <= '0;
      state.interrupt_control <= `ICTL_RESET_CONTROL; // R13
      state.per_pin_change_enable_reg <= `ICTL_RESET_PIN_ENABLE;
      state.pullup_enable <= `ICTL_RESET_PULLUP;
    end
    else
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // ready only shows while the access phase is on the bus
  always_comb
  begin
    apb_rsp = state.rsp;
    apb_rsp.pready = state.rsp.pready && apb_req.psel && apb_req.penable;
  end

  assign pullup_enable = state.pullup_enable;
  assign irq = state.irq;

endmodule : core_interrupt_control

`default_nettype wire

// File: core_interrupt_control_map.svh
// offsets, field positions and reset values of the interrupt control block
// assumes inclusion by the design module
`ifndef CORE_INTERRUPT_CONTROL_MAP_SVH
`define CORE_INTERRUPT_CONTROL_MAP_SVH

`define ICTL_OFS_CONTROL 12'h000
`define ICTL_OFS_PIN_ENABLE 12'h004
`define ICTL_OFS_PORT_B 12'h008
`define ICTL_OFS_PULLUP 12'h00C
`define ICTL_OFS_STATUS 12'h010

`define ICTL_BIT_GLOBAL 7
`define ICTL_BIT_PERIPH 6
`define ICTL_BIT_T0_EN 5
`define ICTL_BIT_EXT_EN 4
`define ICTL_BIT_PB_EN 3
`define ICTL_BIT_T0_FLAG 2
`define ICTL_BIT_EXT_FLAG 1
`define ICTL_BIT_PB_FLAG 0

`define ICTL_RESET_CONTROL 8'h00
`define ICTL_RESET_PIN_ENABLE 8'h00
`define ICTL_RESET_PULLUP 8'h00

`endif

// File: core_interrupt_control_pkg.sv
// types shared by the interrupt control block
// assumes the map header holds the numbers
package core_interrupt_control_pkg;

  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_group_enable;
    logic timer0_overflow_irq_enable;
    logic ext_pin_irq_enable;
    logic port_b_change_irq_enable;
    logic timer0_overflow_flag;
    logic ext_pin_irq_flag;
    logic port_b_change_flag;
  } interrupt_control_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    interrupt_control_t interrupt_control;
    logic [7:0] per_pin_change_enable_reg;
    logic [7:0] pullup_enable;
    logic [7:0] port_b_last;
    logic ext_pin_last;
    logic timer0_pending;
    logic irq;
    apb_rsp_t rsp;
  } state_t;

endpackage : core_interrupt_control_pkg

// File: core_model.sv
// core side: counts the interrupt requests it takes
// assumes irq is a level held until software clears the source
`timescale 1ns/1ps
`default_nettype none
module core_model
(
  input wire logic mclk,
  input wire logic irq,
  output logic [7:0] taken
);
  logic last = 1'b0;
  initial taken = 8'h00;
  always @(posedge mclk)
  begin
    last <= irq;
    taken <= taken + {7'h00, (irq === 1'b1) && (last === 1'b0)};
  end
endmodule : core_model
`default_nettype wire

// File: ictl_checker.sv
// port assertions for the interrupt control block
// assumes bind into the design top module
`timescale 1ns/1ps
`default_nettype none
module ictl_checker
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire core_interrupt_control_pkg::apb_req_t apb_req,
  input wire core_interrupt_control_pkg::apb_rsp_t apb_rsp,
  input wire logic timer0_rollover,
  input wire logic [7:0] pullup_enable,
  input wire logic irq
);
  logic [7:5] en;
  logic acc;
  assign acc = apb_req.psel && apb_req.penable;
  // enables last written to the control register
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      en <= 3'h0;
    else if (acc && apb_req.pwrite && apb_req.paddr == 12'h000)
      en <= apb_req.pwdata[7:5];
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  property p_rdy; acc |-> apb_rsp.pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_idle; !acc |-> !apb_rsp.pready; endproperty
  a_idle: assert property (p_idle) else $error("stray ready");
  property p_err; acc && apb_req.paddr > 12'h010 |-> apb_rsp.pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_ok; acc && apb_req.paddr == 12'h000 |-> !apb_rsp.pslverr;
  endproperty
  a_ok: assert property (p_ok) else $error("bad error");
  property p_hi; acc |-> apb_rsp.prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper bits");
  property p_gie; !en[7] [*2] |-> !irq; endproperty
  a_gie: assert property (p_gie) else $error("irq masked");
  property p_t0; timer0_rollover && en[7] && en[5] |-> ##[1:3] irq;
  endproperty
  a_t0: assert property (p_t0) else $error("no timer irq");
  property p_pull; acc && apb_req.pwrite && apb_req.paddr == 12'h00C |=>
    pullup_enable == $past(apb_req.pwdata[7:0]); endproperty
  a_pull: assert property (p_pull) else $error("pull-up");
  c_t0: cover property (timer0_rollover && en[7] && en[5]);
  c_err: cover property (acc && apb_rsp.pslverr);
  c_irq: cover property ($rose(irq));
endmodule : ictl_checker
bind core_interrupt_control ictl_checker i_chk (.mclk(mclk),
  .reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .timer0_rollover(timer0_rollover), .pullup_enable(pullup_enable),
  .irq(irq));
`default_nettype wire

// File: test_core_interrupt_control.sv
// bench: register rows, eight event rows over the interrupt sources, then a reset
// assumes the checker bind and the core model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_core_interrupt_control;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  core_interrupt_control_pkg::apb_req_t req = '0;
  core_interrupt_control_pkg::apb_rsp_t rsp;
  logic t0 = 1'b0;
  logic ext = 1'b0;
  logic per = 1'b0;
  logic [7:0] pb = 8'h00;
  logic [7:0] pull;
  logic irq;
  logic [7:0] taken;
  logic [32:0] rd;
  int failures = 0;
  int comparisons = 0;
  logic [19:0] rows [4] = '{20'h00038, 20'h004A5, 20'h00C5A, 20'h00000};
  logic [15:0] ev [8] = '{16'h7F00, 16'hFF01, 16'hA011, 16'h8010,
    16'h9021, 16'h8831, 16'hC041, 16'h8040};
  always #25 mclk = ~mclk;
  core_interrupt_control i_dut (.mclk(mclk), .reset_n(reset_n),
    .apb_req(req), .apb_rsp(rsp), .timer0_rollover(t0), .ext_pin(ext),
    .port_b_a(pb), .peripheral_irq(per), .pullup_enable(pull), .irq(irq));
  core_model i_core (.mclk(mclk), .irq(irq), .taken(taken));
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    comparisons++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask : chk
  task automatic results();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge mclk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 9);
    rd = {rsp.pslverr, rsp.prdata};
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (rsp.pready !== 1'b1)
    begin
      failures++;
      results();
    end
  endtask : apb
  // one event source fired, flags and request settle before the check
  task automatic fire(input logic [3:0] s);
    @(posedge mclk);
    case (s)
      4'h1: t0 <= 1'b1;
      4'h2: ext <= 1'b1;
      4'h3: pb <= ~pb;
      4'h4: per <= 1'b1;
      default: ;
    endcase
    @(posedge mclk);
    t0 <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask : fire
  initial
  begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i][19:8], rows[i][7:0]);
      apb(1'b0, rows[i][19:8], 8'h00);
      chk(rd, {25'h0, rows[i][7:0]});
    end
    chk({25'h0, pull}, 33'h05A);
    apb(1'b0, 12'h014, 8'h00);
    chk({rd[32], 32'h0}, 33'h100000000);
    foreach (ev[i])
    begin
      apb(1'b1, 12'h000, 8'h00);
      apb(1'b1, 12'h000, ev[i][15:8]);
      fire(ev[i][7:4]);
      chk({32'h0, irq}, {32'h0, ev[i][0]});
      apb(1'b0, 12'h000, 8'h00);
      chk(rd, {25'h0, ev[i][15:8] | (8'h08 >> ev[i][7:4])});
      ext <= 1'b0;
      per <= 1'b0;
    end
    chk({25'h0, taken}, 33'h005);
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    apb(1'b0, 12'h000, 8'h00);
    chk(rd, 33'h0);
    chk({25'h0, pull}, 33'h0);
    results();
  end
endmodule : test_core_interrupt_control
`default_nettype wire
